// ---- rtl/gpcg_defines.vh ----
// Offsets, field positions, reset values and mode codes for port clock gating.
// Assumes a 12-bit byte address on an APB slave with 32-bit data.
`ifndef GPCG_DEFINES_VH
`define GPCG_DEFINES_VH

`define GPCG_ADDR_W 12
`define GPCG_NPORTS 8

`define GPCG_OFF_RUN_GATE 12'h108
`define GPCG_OFF_SLEEP_GATE 12'h118
`define GPCG_OFF_DEEP_GATE 12'h128
`define GPCG_OFF_RUN_CFG 12'h060
`define GPCG_OFF_STATUS 12'h130
`define GPCG_OFF_FAULT_CNT 12'h134

`define GPCG_GATE_RESET 8'h00
`define GPCG_REG_RESET 32'h00000000
`define GPCG_ACG_BIT 0

`define GPCG_PORT_A 0
`define GPCG_PORT_B 1
`define GPCG_PORT_C 2
`define GPCG_PORT_D 3
`define GPCG_PORT_E 4
`define GPCG_PORT_F 5
`define GPCG_PORT_G 6
`define GPCG_PORT_H 7

`define GPCG_STAT_EN_LSB 0
`define GPCG_STAT_MODE_LSB 8
`define GPCG_STAT_FAULT_LSB 16
`define GPCG_FCNT_IDX_LSB 8

`define GPCG_MODE_RUN 2'h0
`define GPCG_MODE_SLEEP 2'h1
`define GPCG_MODE_DEEP 2'h2

`define GPCG_FCNT_MAX 8'hff

`endif

// ---- rtl/gpcg_fault_check.v ----
// Per-port access check against the applied clock enables.
// Assumes port_req is a one-cycle strobe from bus decode on pclk.
`timescale 1ns/10ps
`include "gpcg_defines.vh"

module gpcg_fault_check (
  input wire pclk,
  input wire presetn,
  input wire [7:0] port_req,
  input wire [7:0] clk_en,
  output wire [7:0] port_grant,
  output reg fault_pulse_reg,
  output reg [7:0] fault_ports_reg
);

  wire [7:0] miss;

  genvar g;
  generate
    for (g = 0; g < `GPCG_NPORTS; g = g + 1) begin : gen_port
      // Clocked port completes normally
      assign port_grant[g] = port_req[g] & clk_en[g];
      // Unclocked port faults
      assign miss[g] = port_req[g] & ~clk_en[g];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_pulse_reg <= 1'b0;
      fault_ports_reg <= 8'h00;
    end else begin
      fault_pulse_reg <= |miss;
      fault_ports_reg <= miss;
    end
  end

endmodule

// ---- rtl/gpcg_top.v ----
// Port clock gating control with APB register access.
// Assumes power mode requests and port strobes come from logic on pclk.
`timescale 1ns/10ps
`include "gpcg_defines.vh"

module gpcg_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sleep_req,
  input wire deepsleep_req,
  input wire [7:0] port_req,
  output wire [7:0] port_clk_en,
  output wire [7:0] port_grant,
  output wire port_fault
);

  // Gating registers
  reg [7:0] run_gate_reg;
  reg [7:0] run_gate_next;
  reg [7:0] sleep_gate_reg;
  reg [7:0] sleep_gate_next;
  reg [7:0] deep_gate_reg;
  reg [7:0] deep_gate_next;
  reg acg_reg;
  reg acg_next;

  // Applied state
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg [7:0] clk_en_reg;
  reg [7:0] clk_en_next;

  // Fault bookkeeping
  reg [7:0] fault_seen_reg;
  wire [7:0] fault_seen_next;
  wire [7:0] seen_clr;
  reg [7:0] fault_cnt_reg;
  reg [7:0] fault_cnt_next;
  reg [2:0] last_port_reg;
  reg [2:0] last_port_next;

  // Read data
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg [31:0] rd_data;

  wire fault_pulse;
  wire [7:0] fault_ports;

  // Bus phases
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  wire rd_setup;

  // Address decode
  wire hit_run;
  wire hit_sleep;
  wire hit_deep;
  wire hit_cfg;
  wire hit_stat;
  wire hit_fcnt;
  wire addr_hit;

  // Write strobes
  wire wr_run;
  wire wr_sleep;
  wire wr_deep;
  wire wr_cfg;
  wire wr_stat;
  wire wr_fcnt;

  reg [2:0] first_idx;
  integer i;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign rd_setup = setup_phase & ~pwrite;
  assign wr_en = access_phase & pwrite & pready;

  assign hit_run = (paddr == `GPCG_OFF_RUN_GATE);
  assign hit_sleep = (paddr == `GPCG_OFF_SLEEP_GATE);
  assign hit_deep = (paddr == `GPCG_OFF_DEEP_GATE);
  assign hit_cfg = (paddr == `GPCG_OFF_RUN_CFG);
  assign hit_stat = (paddr == `GPCG_OFF_STATUS);
  assign hit_fcnt = (paddr == `GPCG_OFF_FAULT_CNT);
  assign addr_hit = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_fcnt;

  assign wr_run = wr_en & hit_run;
  assign wr_sleep = wr_en & hit_sleep;
  assign wr_deep = wr_en & hit_deep;
  assign wr_cfg = wr_en & hit_cfg;
  assign wr_stat = wr_en & hit_stat;
  assign wr_fcnt = wr_en & hit_fcnt;

  // Zero wait state slave
  assign pready = 1'b1;
  // Unmapped address answers with an error
  assign pslverr = access_phase & ~addr_hit;
  assign prdata = prdata_reg;

  // Port bus check
  gpcg_fault_check u_fault (
    .pclk(pclk),
    .presetn(presetn),
    .port_req(port_req),
    .clk_en(clk_en_reg),
    .port_grant(port_grant),
    .fault_pulse_reg(fault_pulse),
    .fault_ports_reg(fault_ports)
  );

  assign port_fault = fault_pulse;
  assign port_clk_en = clk_en_reg;

  // Gating register writes
  always @* begin
    run_gate_next = run_gate_reg;
    sleep_gate_next = sleep_gate_reg;
    deep_gate_next = deep_gate_reg;
    acg_next = acg_reg;
    if (wr_run) begin
      // Bits 7..0 map ports H..A, upper bits dropped
      run_gate_next = pwdata[7:0];
    end
    if (wr_sleep) begin
      sleep_gate_next = pwdata[7:0];
    end
    if (wr_deep) begin
      deep_gate_next = pwdata[7:0];
    end
    if (wr_cfg) begin
      acg_next = pwdata[`GPCG_ACG_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_gate_reg <= `GPCG_GATE_RESET;
      sleep_gate_reg <= `GPCG_GATE_RESET;
      deep_gate_reg <= `GPCG_GATE_RESET;
      acg_reg <= 1'b0;
    end else begin
      run_gate_reg <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      deep_gate_reg <= deep_gate_next;
      acg_reg <= acg_next;
    end
  end

  // Power mode states
  localparam ST_RUN = `GPCG_MODE_RUN;
  localparam ST_SLEEP = `GPCG_MODE_SLEEP;
  localparam ST_DEEP = `GPCG_MODE_DEEP;

  // Power mode tracking, deep sleep has priority
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      ST_RUN: begin
        if (deepsleep_req) begin
          mode_next = ST_DEEP;
        end else if (sleep_req) begin
          mode_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (deepsleep_req) begin
          mode_next = ST_DEEP;
        end else if (!sleep_req) begin
          mode_next = ST_RUN;
        end
      end
      ST_DEEP: begin
        if (!deepsleep_req) begin
          if (sleep_req) begin
            mode_next = ST_SLEEP;
          end else begin
            mode_next = ST_RUN;
          end
        end
      end
      default: begin
        mode_next = ST_RUN;
      end
    endcase
  end

  // Select the gating set for the current mode
  always @* begin
    case (mode_reg)
      ST_RUN: begin
        clk_en_next = run_gate_reg;
      end
      ST_SLEEP: begin
        // Without auto gating the run set stays in force
        if (acg_reg) begin
          clk_en_next = sleep_gate_reg;
        end else begin
          clk_en_next = run_gate_reg;
        end
      end
      ST_DEEP: begin
        if (acg_reg) begin
          clk_en_next = deep_gate_reg;
        end else begin
          clk_en_next = run_gate_reg;
        end
      end
      default: begin
        clk_en_next = run_gate_reg;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ST_RUN;
      clk_en_reg <= `GPCG_GATE_RESET;
    end else begin
      mode_reg <= mode_next;
      clk_en_reg <= clk_en_next;
    end
  end

  // Lowest faulting port index
  always @* begin
    first_idx = 3'h0;
    for (i = `GPCG_NPORTS - 1; i >= 0; i = i - 1) begin
      if (fault_ports[i]) begin
        first_idx = i[2:0];
      end
    end
  end

  // Sticky fault flag per port, a new fault wins over its clear
  genvar p;
  generate
    for (p = 0; p < `GPCG_NPORTS; p = p + 1) begin : gen_seen
      assign seen_clr[p] = wr_stat & pwdata[`GPCG_STAT_FAULT_LSB + p];
      assign fault_seen_next[p] = fault_ports[p] | (fault_seen_reg[p] & ~seen_clr[p]);
    end
  endgenerate

  // Fault count and last port, a new fault wins over a clear
  always @* begin
    fault_cnt_next = fault_cnt_reg;
    last_port_next = last_port_reg;
    if (wr_fcnt) begin
      fault_cnt_next = 8'h00;
    end
    if (fault_pulse) begin
      last_port_next = first_idx;
      if (fault_cnt_next != `GPCG_FCNT_MAX) begin
        fault_cnt_next = fault_cnt_next + 8'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_seen_reg <= 8'h00;
      fault_cnt_reg <= 8'h00;
      last_port_reg <= 3'h0;
    end else begin
      fault_seen_reg <= fault_seen_next;
      fault_cnt_reg <= fault_cnt_next;
      last_port_reg <= last_port_next;
    end
  end

  // Read mux, reserved bits read zero
  always @* begin
    rd_data = `GPCG_REG_RESET;
    if (hit_run) begin
      rd_data[7:0] = run_gate_reg;
    end
    if (hit_sleep) begin
      rd_data[7:0] = sleep_gate_reg;
    end
    if (hit_deep) begin
      rd_data[7:0] = deep_gate_reg;
    end
    if (hit_cfg) begin
      rd_data[`GPCG_ACG_BIT] = acg_reg;
    end
    if (hit_stat) begin
      rd_data[`GPCG_STAT_EN_LSB +: 8] = clk_en_reg;
      rd_data[`GPCG_STAT_MODE_LSB +: 2] = mode_reg;
      rd_data[`GPCG_STAT_FAULT_LSB +: 8] = fault_seen_reg;
    end
    if (hit_fcnt) begin
      rd_data[7:0] = fault_cnt_reg;
      rd_data[`GPCG_FCNT_IDX_LSB +: 3] = last_port_reg;
    end
  end

  // Read data captured in the setup cycle
  always @* begin
    prdata_next = prdata_reg;
    if (rd_setup) begin
      prdata_next = rd_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `GPCG_REG_RESET;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

endmodule

// ---- verif/gpcg_properties.sv ----
// Checker for port clock gating, watching the top ports only.
// Assumes pclk is the only clock and presetn is asynchronous, active low.
`timescale 1ns/10ps
module gpcg_properties (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sleep_req,
  input wire deepsleep_req,
  input wire [7:0] port_req,
  input wire [7:0] port_clk_en,
  input wire [7:0] port_grant,
  input wire port_fault
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire gate = paddr == 12'h108 || paddr == 12'h118;
  wire mapped = gate || paddr == 12'h128 || paddr == 12'h060 || paddr == 12'h130 ||
    paddr == 12'h134;
  wire run = !sleep_req && !deepsleep_req;
  wire miss = |(port_req & ~port_clk_en);
  AST_GRANT: assert property (port_grant == (port_req & port_clk_en))
    else $error("grant differs from enabled requests");
  AST_FAULT: assert property (miss |=> port_fault)
    else $error("no fault after access to gated port");
  AST_NO_FAULT: assert property (!miss |=> !port_fault)
    else $error("fault without gated access");
  AST_READY: assert property (acc |-> pready)
    else $error("access not completed");
  AST_MAPPED: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped register");
  AST_UNMAPPED: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  AST_RSVD_ZERO: assert property (acc && !pwrite && gate |-> prdata[31:8] == 24'h0)
    else $error("reserved gate bits not zero");
  AST_RUN_APPLY: assert property ((acc && pwrite && paddr == 12'h108 && run) ##1 run
    |=> port_clk_en == $past(pwdata[7:0], 2))
    else $error("run gate value not applied");
  cover property (acc && pwrite && paddr == 12'h108);
  cover property (port_fault);
  cover property (acc && pslverr);
endmodule

bind gpcg_top gpcg_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .deepsleep_req(deepsleep_req),
  .port_req(port_req), .port_clk_en(port_clk_en), .port_grant(port_grant),
  .port_fault(port_fault));

// ---- verif/gpcg_top_bench.sv ----
// Self-checking bench for port clock gating over APB.
// Assumes the checker is bound separately; zero-wait slave is still polled.
`timescale 1ns/10ps
module gpcg_top_bench;
  reg pclk, presetn, psel, penable, pwrite, sleep_req, deepsleep_req, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd, v, s, d;
  reg [7:0] port_req;
  wire [31:0] prdata;
  wire pready, pslverr, port_fault;
  wire [7:0] port_clk_en, port_grant;
  integer seed, err_count, total_checks, i, k;
  gpcg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .deepsleep_req(deepsleep_req),
    .port_req(port_req), .port_clk_en(port_clk_en), .port_grant(port_grant),
    .port_fault(port_fault));
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  function [31:0] gexp(input [31:0] x);
    gexp = {24'h0, x[7:0]};
  endfunction
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] x);
    integer n;
    begin
      n = 0;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= x;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 20) begin
        err_count = err_count + 1;
        report_and_stop;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  initial begin
    seed = 20;
    err_count = 0;
    total_checks = 0;
    {presetn, psel, penable, pwrite, sleep_req, deepsleep_req} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    port_req = 8'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({24'h0, port_clk_en}, 32'h0);
    apb(0, 12'h108, 32'h0);
    chk(rd, 32'h0);
    apb(0, 12'h118, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    for (k = 0; k < 4; k = k + 1) begin
      v = (k == 0) ? 32'hffffffff : $random(seed);
      apb(1, 12'h108, v);
      apb(0, 12'h108, 32'h0);
      chk(rd, gexp(v));
      chk({24'h0, port_clk_en}, {24'h0, v[7:0]});
      for (i = 0; i < 8; i = i + 1) begin
        port_req <= 8'h1 << i;
        @(negedge pclk);
        chk({24'h0, port_grant}, {24'h0, v[7:0] & (8'h1 << i)});
        @(posedge pclk);
        port_req <= 8'h0;
        @(negedge pclk);
        chk({31'h0, port_fault}, {31'h0, !v[i]});
        @(posedge pclk);
      end
    end
    $display("run gate test done");
    s = $random(seed);
    d = $random(seed);
    apb(1, 12'h118, s);
    apb(0, 12'h118, 32'h0);
    chk(rd, gexp(s));
    apb(1, 12'h128, d);
    apb(0, 12'h128, 32'h0);
    chk(rd, gexp(d));
    apb(1, 12'h060, 32'h1);
    sleep_req <= 1;
    repeat (3) @(posedge pclk);
    chk({24'h0, port_clk_en}, {24'h0, s[7:0]});
    deepsleep_req <= 1;
    repeat (3) @(posedge pclk);
    chk({24'h0, port_clk_en}, {24'h0, d[7:0]});
    apb(1, 12'h060, 32'h0);
    repeat (2) @(posedge pclk);
    chk({24'h0, port_clk_en}, {24'h0, v[7:0]});
    sleep_req <= 0;
    deepsleep_req <= 0;
    $display("mode test done");
    apb(0, 12'h10c, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(0, 12'h108, 32'h0);
    chk({31'h0, er}, 32'h0);
    $display("address test done");
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h108, 32'h0);
    chk(rd, 32'h0);
    chk({24'h0, port_clk_en}, 32'h0);
    $display("second reset test done");
    port_req <= 8'h24;
    @(posedge pclk);
    port_req <= 8'h0;
    repeat (2) @(posedge pclk);
    apb(0, 12'h130, 32'h0);
    chk(rd, 32'h00240000);
    apb(0, 12'h134, 32'h0);
    chk(rd, 32'h00000201);
    apb(1, 12'h130, 32'h00040000);
    apb(1, 12'h134, 32'h0);
    apb(0, 12'h130, 32'h0);
    chk(rd, 32'h00200000);
    apb(0, 12'h134, 32'h0);
    chk(rd, 32'h00000200);
    $display("fault status test done");
    report_and_stop;
  end
endmodule
